// *** logic/cmp_ctrl.sv ***
// Purpose: comparator response mode, edge interrupt enables, input mux select
// Assumes: register port and comparator output synchronous to mclk_i
// Notes: edge flags live here; their software clear arrives as strobes

// ************************************************************
// comparator mode and input select control
// ************************************************************

module cmp_ctrl
  import cmp_pkg::*;
#(
  parameter int N_PINS = 10     // pins per input mux, higher codes pick none
)(
  input wire logic mclk_i,                   // system clock
  input wire logic sys_rst_i,                // sync reset, active high
  input wire logic ce_i,                     // clock enable, freezes all state
  input wire logic [7:0] sfr_addr_i,         // register byte address
  input wire logic sfr_wr_i,                 // register write strobe
  input wire logic [7:0] sfr_wdata_i,        // register write data
  input wire logic sfr_rd_i,                 // register read strobe
  output logic [7:0] sfr_rdata_o,            // register read data, one cycle later
  input wire logic cmp_out_i,                // comparator output level
  input wire logic rise_flag_clr_i,          // software clear of the rising flag
  input wire logic fall_flag_clr_i,          // software clear of the falling flag
  output cmp_mode_t mode_o,                  // response mode and edge enables
  output cmp_mux_t mux_o,                    // raw input select codes
  output logic [N_PINS-1:0] pos_pin_sel_o,   // one-hot positive input pin, all zero for none codes
  output logic [N_PINS-1:0] neg_pin_sel_o,   // one-hot negative input pin, all zero for none codes
  output cmp_edge_t edge_flags_o,            // sticky edge flags
  output logic cmp_irq_req_o                 // request to the interrupt controller
);

  // ************************************************************
  // reset images and state
  // ************************************************************

  // reset image of the mode register, split into its fields
  localparam cmp_mode_t MODE_RST_VAL = '{
    rise_edge_irq_enable: CMP_MODE_RST[CMP_RIE_BIT],
    fall_edge_irq_enable: CMP_MODE_RST[CMP_FIE_BIT],
    response_mode_field: cmp_resp_t'(CMP_MODE_RST[CMP_MODE_LSB +: 2])
  };
  localparam cmp_mux_t MUX_RST_VAL = cmp_mux_t'(CMP_MUX_RST);

  cmp_mode_t mode_reg, mode_next;
  cmp_mux_t mux_reg, mux_next;
  cmp_edge_t flag_reg, flag_next;
  logic irq_reg, irq_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [N_PINS-1:0] pos_sel_reg, pos_sel_next;
  logic [N_PINS-1:0] neg_sel_reg, neg_sel_next;
  cmp_edge_t edge_pulse;
  logic mode_hit;
  logic mux_hit;

  // ************************************************************
  // edge detection
  // ************************************************************

  // one-cycle pulses from the comparator level
  cmp_edge_det u_edge (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .level_i(cmp_out_i),
    .edge_o(edge_pulse)
  );

  // ************************************************************
  // register port decode
  // ************************************************************

  // address match, shared by reads and writes
  assign mode_hit = (sfr_addr_i == CMP_MODE_ADDR);
  assign mux_hit = (sfr_addr_i == CMP_MUX_ADDR);

  // next values of the two control registers
  always_comb begin
    mode_next = mode_reg;
    mux_next = mux_reg;
    if (sfr_wr_i && mode_hit) begin
      mode_next.rise_edge_irq_enable = sfr_wdata_i[CMP_RIE_BIT];
      mode_next.fall_edge_irq_enable = sfr_wdata_i[CMP_FIE_BIT];
      mode_next.response_mode_field = cmp_resp_t'(sfr_wdata_i[CMP_MODE_LSB +: 2]);
      // unused bits dropped, no storage for them at all
    end
    if (sfr_wr_i && mux_hit) begin
      mux_next.negative_input_select = sfr_wdata_i[CMP_NEG_LSB +: CMP_SEL_W];
      mux_next.positive_input_select = sfr_wdata_i[CMP_POS_LSB +: CMP_SEL_W];
    end
  end

  // read data; a read in the cycle of a write returns the old value
  always_comb begin
    rdata_next = rdata_reg;
    if (sfr_rd_i) begin
      rdata_next = CMP_RD_UNMAPPED;
      if (mode_hit) begin
        rdata_next[CMP_RIE_BIT] = mode_reg.rise_edge_irq_enable;
        rdata_next[CMP_FIE_BIT] = mode_reg.fall_edge_irq_enable;
        rdata_next[CMP_MODE_LSB +: 2] = mode_reg.response_mode_field;
      end else if (mux_hit) begin
        rdata_next[CMP_NEG_LSB +: CMP_SEL_W] = mux_reg.negative_input_select;
        rdata_next[CMP_POS_LSB +: CMP_SEL_W] = mux_reg.positive_input_select;
      end
    end
  end

  // ************************************************************
  // input pin selection
  // ************************************************************

  // decoded from the next mux value so select and code never disagree
  // one-hot pin decode
  for (genvar k = 0; k < N_PINS; k++) begin : g_pin
    assign pos_sel_next[k] = (mux_next.positive_input_select == CMP_SEL_W'(k));
    assign neg_sel_next[k] = (mux_next.negative_input_select == CMP_SEL_W'(k));
  end

  // ************************************************************
  // edge flags and interrupt request
  // ************************************************************

  // sticky flags; an edge in the cycle of a clear wins, so none is lost
  always_comb begin
    flag_next = flag_reg;
    if (rise_flag_clr_i) begin
      flag_next.rise = 1'b0;
    end
    if (fall_flag_clr_i) begin
      flag_next.fall = 1'b0;
    end
    if (edge_pulse.rise) begin
      flag_next.rise = 1'b1;
    end
    if (edge_pulse.fall) begin
      flag_next.fall = 1'b1;
    end
    irq_next = (flag_next.rise & mode_next.rise_edge_irq_enable)
      | (flag_next.fall & mode_next.fall_edge_irq_enable);
  end

  // ************************************************************
  // registers
  // ************************************************************

  // all state, frozen while ce_i is low
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      mode_reg <= MODE_RST_VAL;
      mux_reg <= MUX_RST_VAL;
      flag_reg <= '0;
      irq_reg <= 1'b0;
      rdata_reg <= CMP_RD_UNMAPPED;
      pos_sel_reg <= '0;
      neg_sel_reg <= '0;
    end else if (ce_i) begin
      mode_reg <= mode_next;
      mux_reg <= mux_next;
      flag_reg <= flag_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
      pos_sel_reg <= pos_sel_next;
      neg_sel_reg <= neg_sel_next;
    end
  end

  // outputs straight from flops
  assign sfr_rdata_o = rdata_reg;
  assign mode_o = mode_reg;
  assign mux_o = mux_reg;
  assign pos_pin_sel_o = pos_sel_reg;
  assign neg_pin_sel_o = neg_sel_reg;
  assign edge_flags_o = flag_reg;
  assign cmp_irq_req_o = irq_reg;

  // ************************************************************
  // assertions
  // ************************************************************

  default clocking cb_main @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  // register writes land in the named fields
  a_rie_write: assert property (ce_i && sfr_wr_i && mode_hit |=>
    mode_o.rise_edge_irq_enable == $past(sfr_wdata_i[CMP_RIE_BIT]))
    else $error("rising enable write lost");
  a_fie_write: assert property (ce_i && sfr_wr_i && mode_hit |=>
    mode_o.fall_edge_irq_enable == $past(sfr_wdata_i[CMP_FIE_BIT]))
    else $error("falling enable write lost");
  a_mode_write: assert property (ce_i && sfr_wr_i && mode_hit |=>
    mode_o.response_mode_field == $past(sfr_wdata_i[CMP_MODE_LSB +: 2]))
    else $error("response mode write lost");

  // unused mode bits never read back as ones
  a_unused_zero: assert property (ce_i && sfr_rd_i && mode_hit |=>
    sfr_rdata_o[7:6] == 2'b00 && sfr_rdata_o[3:2] == 2'b00)
    else $error("unused mode bits read nonzero");

  // codes past the last pin connect nothing, others exactly one pin
  a_neg_none: assert property (mux_o.negative_input_select > CMP_SEL_LAST_PIN |->
    neg_pin_sel_o == '0)
    else $error("negative input connected for a none code");
  a_pos_one: assert property (mux_o.positive_input_select <= CMP_SEL_LAST_PIN |->
    $onehot(pos_pin_sel_o))
    else $error("positive input not one pin");

  // edges set sticky flags, flags hold until cleared
  a_rise_set: assert property (ce_i && edge_pulse.rise |=> edge_flags_o.rise)
    else $error("rising edge did not set its flag");
  a_fall_hold: assert property (ce_i && edge_flags_o.fall && !fall_flag_clr_i |=>
    edge_flags_o.fall)
    else $error("falling flag dropped without clear");
  a_irq_req: assert property (cmp_irq_req_o ==
    ((edge_flags_o.rise & mode_o.rise_edge_irq_enable)
    | (edge_flags_o.fall & mode_o.fall_edge_irq_enable)))
    else $error("interrupt request disagrees with flags");

  // reset loads both registers regardless of the clock enable
  a_reset_load: assert property (disable iff (1'b0) sys_rst_i |=>
    mode_o == MODE_RST_VAL && mux_o == MUX_RST_VAL)
    else $error("reset values not loaded");

  // main scenarios
  c_rise_edge: cover property (ce_i && edge_pulse.rise);
  c_fall_edge: cover property (ce_i && edge_pulse.fall);
  c_irq_req: cover property (cmp_irq_req_o);
  c_pin_none: cover property (pos_pin_sel_o == '0 && neg_pin_sel_o != '0);

endmodule

// *** logic/cmp_pkg.sv ***
// Purpose: shared constants and carriers for the comparator mode/mux block
// Assumes: 8-bit special function register bus, 20 MHz system clock
// Notes: register offsets are the byte addresses on the register port
package cmp_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] CMP_MODE_ADDR = 8'h9d; // comparator_mode_register
  localparam logic [7:0] CMP_MUX_ADDR = 8'h9f;  // comparator_mux_register
  localparam logic [7:0] CMP_MODE_RST = 8'h02;
  localparam logic [7:0] CMP_MUX_RST = 8'hff;
  localparam logic [7:0] CMP_RD_UNMAPPED = 8'h00;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CMP_RIE_BIT = 5;
  localparam int CMP_FIE_BIT = 4;
  localparam int CMP_MODE_LSB = 0;
  localparam int CMP_NEG_LSB = 4;
  localparam int CMP_POS_LSB = 0;
  localparam int CMP_SEL_W = 4;
  // highest select code that still names a pin; above it nothing connects
  localparam logic [3:0] CMP_SEL_LAST_PIN = 4'h9;

  // response modes, fastest first
  typedef enum logic [1:0] {
    CMP_MODE_FAST = 2'h0,
    CMP_MODE_1 = 2'h1,
    CMP_MODE_2 = 2'h2,
    CMP_MODE_SLOW = 2'h3
  } cmp_resp_t;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic rise_edge_irq_enable;
    logic fall_edge_irq_enable;
    cmp_resp_t response_mode_field;
  } cmp_mode_t;

  typedef struct packed {
    logic [3:0] negative_input_select;
    logic [3:0] positive_input_select;
  } cmp_mux_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } cmp_edge_t;

endpackage

// *** logic/cmp_edge_det.sv ***
// Purpose: registered edge pulses from the comparator output level
// Assumes: comparator output already synchronous to mclk_i
// Notes: first sample after reset only primes the history, no edge
module cmp_edge_det
  import cmp_pkg::*;
(
  input wire logic mclk_i,      // system clock
  input wire logic sys_rst_i,   // sync reset, active high
  input wire logic ce_i,        // clock enable
  input wire logic level_i,     // comparator output level
  output cmp_edge_t edge_o      // one-cycle edge pulses
);

  logic prev_reg, prev_next;
  logic primed_reg, primed_next;
  cmp_edge_t edge_reg, edge_next;

  // next history and edge pulses
  always_comb begin
    prev_next = level_i;
    primed_next = 1'b1;
    edge_next.rise = primed_reg & level_i & ~prev_reg;
    edge_next.fall = primed_reg & ~level_i & prev_reg;
  end

  // registers, frozen while ce_i is low
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      prev_reg <= 1'b0;
      primed_reg <= 1'b0;
      edge_reg <= '0;
    end else if (ce_i) begin
      prev_reg <= prev_next;
      primed_reg <= primed_next;
      edge_reg <= edge_next;
    end
  end

  assign edge_o = edge_reg;

endmodule

// *** sim/cmp_ana_model.sv ***
// Purpose: analog comparator model
// Assumes: input levels settle at once
// Notes: output high while pos above neg
module cmp_ana_model (
  input wire logic [7:0] pos_i, // positive level
  input wire logic [7:0] neg_i, // negative level
  output logic out_o            // comparator output
);
  timeunit 1ns;
  timeprecision 1ns;
  assign out_o = pos_i > neg_i;
endmodule

// *** sim/testbench.sv ***
// Purpose: register, pin select, edge flag and request checks
// Assumes: pulses trail level by one cycle
// Notes: edge counts compared at the end, lag left free
module testbench;
  import cmp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 0, sys_rst_i = 1, lvl, prv = 0;
  logic ce = 1, wr = 0, rd = 0, rclr = 0, fclr = 0, irq;
  logic [7:0] p = 0, n = 0, addr = 0, wdata = 0, rdata, rval;
  logic [9:0] psel, nsel;
  logic [31:0] s = 32'h2117;
  int mismatches = 0, n_compared = 0, er = 0, ef = 0, sr = 0, sf = 0;
  cmp_edge_t e, flags;
  cmp_mode_t mode;
  cmp_mux_t mux;
  always #25 mclk_i = ~mclk_i;
  cmp_ana_model m (.pos_i(p), .neg_i(n), .out_o(lvl));
  cmp_ctrl dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .sfr_addr_i(addr),
    .sfr_wr_i(wr), .sfr_wdata_i(wdata), .sfr_rd_i(rd), .sfr_rdata_o(rdata),
    .cmp_out_i(lvl), .rise_flag_clr_i(rclr), .fall_flag_clr_i(fclr), .mode_o(mode),
    .mux_o(mux), .pos_pin_sel_o(psel), .neg_pin_sel_o(nsel), .edge_flags_o(flags),
    .cmp_irq_req_o(irq));
  assign e = dut.u_edge.edge_o;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic [7:0] exp_mode(input logic [7:0] d);
    return {2'b00, d[5:4], 2'b00, d[1:0]};
  endfunction
  function automatic logic [9:0] exp_sel(input logic [3:0] c);
    return (c <= 4'h9) ? (10'h001 << c) : 10'h000;
  endfunction
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask
  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    @(negedge mclk_i);
    d = rdata;
  endtask
  // tally level edges and pulses
  always @(posedge mclk_i) begin
    prv <= lvl;
    er += !sys_rst_i && !prv && lvl;
    ef += !sys_rst_i && prv && !lvl;
    sr += !sys_rst_i && e.rise === 1'b1;
    sf += !sys_rst_i && e.fall === 1'b1;
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (x !== g) begin
      mismatches++;
      $display("MISMATCH %s exp %0h got %0h", nm, x, g);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk_i);
    sys_rst_i <= 0;
    repeat (3) @(posedge mclk_i);
    sfr_read(CMP_MODE_ADDR, rval);
    chk("mode_rst", 8'h02, rval);
    sfr_read(CMP_MUX_ADDR, rval);
    chk("mux_rst", 8'hff, rval);
    chk("psel_rst", 10'h000, psel);
    // random register writes and readback
    for (int i = 0; i < 40; i++) begin
      s = xs(s);
      sfr_write(CMP_MODE_ADDR, s[7:0]);
      sfr_write(CMP_MUX_ADDR, s[15:8]);
      sfr_read(CMP_MODE_ADDR, rval);
      chk("mode_rd", exp_mode(s[7:0]), rval);
      chk("mode_out", {s[5:4], s[1:0]}, mode);
      sfr_read(CMP_MUX_ADDR, rval);
      chk("mux_rd", s[15:8], rval);
      chk("psel", exp_sel(s[11:8]), psel);
      chk("nsel", exp_sel(s[15:12]), nsel);
    end
    // corners: unused bits, last pin and first none code, frozen write
    sfr_write(CMP_MODE_ADDR, 8'hcc);
    sfr_read(CMP_MODE_ADDR, rval);
    chk("mode_unused", 8'h00, rval);
    sfr_write(CMP_MUX_ADDR, 8'h9a);
    sfr_read(8'h9e, rval);
    chk("unmapped_rd", 8'h00, rval);
    chk("nsel_last", 10'h200, nsel);
    chk("psel_none", 10'h000, psel);
    ce <= 1'b0;
    sfr_write(CMP_MUX_ADDR, 8'h00);
    ce <= 1'b1;
    sfr_read(CMP_MUX_ADDR, rval);
    chk("mux_frozen", 8'h9a, rval);
    // random levels, ties now and then
    for (int i = 0; i < 400; i++) begin
      @(posedge mclk_i);
      s = xs(s);
      p <= s[7:0];
      n <= (i % 7 == 0) ? s[7:0] : s[15:8];
    end
    // directed flag and request sequence
    sfr_write(CMP_MODE_ADDR, 8'h30);
    p <= 8'h00;
    n <= 8'h01;
    repeat (4) @(posedge mclk_i);
    rclr <= 1'b1;
    fclr <= 1'b1;
    @(posedge mclk_i);
    rclr <= 1'b0;
    fclr <= 1'b0;
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    chk("flags_clr", 2'b00, flags);
    chk("irq_idle", 1'b0, irq);
    p <= 8'h02;
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    chk("flags_rise", 2'b10, flags);
    chk("irq_rise", 1'b1, irq);
    sfr_write(CMP_MODE_ADDR, 8'h10);
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    chk("irq_masked", 1'b0, irq);
    chk("flag_sticky", 2'b10, flags);
    p <= 8'h00;
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    chk("flags_both", 2'b11, flags);
    chk("irq_fall", 1'b1, irq);
    // reset in mid-run
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(negedge mclk_i);
    chk("mode_rst2", 4'h2, mode);
    chk("mux_rst2", 8'hff, mux);
    chk("flags_rst2", 2'b00, flags);
    chk("irq_rst2", 1'b0, irq);
    repeat (4) @(posedge mclk_i);
    chk("rise", er, sr);
    chk("fall", ef, sf);
    report_and_stop();
  end
endmodule
